// [src/ctl_pkg.sv]
// Constants for the counter clock and trigger front end
package ctl_pkg;
    // Register byte offsets
    localparam logic [7:0] CTL_OFS_CTRL    = 8'h00;
    localparam logic [7:0] CTL_OFS_DIV     = 8'h04;
    localparam logic [7:0] CTL_OFS_SRC     = 8'h08;
    localparam logic [7:0] CTL_OFS_EDGE    = 8'h0C;
    localparam logic [7:0] CTL_OFS_CMD     = 8'h10;
    localparam logic [7:0] CTL_OFS_COUNTER = 8'h14;
    localparam logic [7:0] CTL_OFS_PERIOD  = 8'h18;
    localparam logic [7:0] CTL_OFS_CC      = 8'h1C;
    localparam logic [7:0] CTL_OFS_CCBUF   = 8'h20;
    localparam logic [7:0] CTL_OFS_STATUS  = 8'h24;
    // Control register fields
    localparam int CTL_EN_BIT     = 0;
    localparam int CTL_LEAVE_BIT  = 4;
    localparam int CTL_PRESC_LSB  = 8;
    localparam int CTL_DOWN_BIT   = 16;
    localparam int CTL_MODE_LSB   = 24;
    // Divider register fields
    localparam int CTL_CDIV_LSB   = 0;
    localparam int CTL_SDIV_LSB   = 8;
    // Operating mode codes
    localparam logic [2:0] CTL_MODE_TIMER = 3'h0;
    localparam logic [2:0] CTL_MODE_CAPT  = 3'h2;
    localparam logic [2:0] CTL_MODE_QUAD  = 3'h3;
    localparam logic [2:0] CTL_MODE_PWM   = 3'h4;
    localparam logic [2:0] CTL_MODE_DT    = 3'h5;
    localparam logic [2:0] CTL_MODE_PR    = 3'h6;
    // Edge conditioner codes
    localparam logic [1:0] CTL_EDGE_RISE  = 2'h0;
    localparam logic [1:0] CTL_EDGE_FALL  = 2'h1;
    localparam logic [1:0] CTL_EDGE_BOTH  = 2'h2;
    localparam logic [1:0] CTL_EDGE_LEVEL = 2'h3;
    // Event slots, also command bit positions
    localparam int CTL_EV_RELOAD  = 0;
    localparam int CTL_EV_START   = 1;
    localparam int CTL_EV_STOP    = 2;
    localparam int CTL_EV_COUNT   = 3;
    localparam int CTL_EV_CAPT    = 4;
    localparam int CTL_NUM_EV     = 5;
    localparam int CTL_NUM_LINES  = 14;
    localparam int CTL_NUM_SRC    = 16;
    // Output pulse length in system cycles
    localparam logic [1:0] CTL_PULSE_SYS = 2'h2;
    // Reset values
    localparam logic [31:0] CTL_CTRL_RST = 32'h0000_0000;
    localparam logic [7:0]  CTL_DIV_RST  = 8'h00;
endpackage

// [src/ctl_front.sv]
// Counter clock, trigger conditioning and trigger output logic for one counter
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - Prescaler divides counter clock by 1..128.
// - Quadrature and dead-time modes skip prescaling.
// - Level count input counts while high.
// - Edge count input counts on detected edges.
// - Quadrature, pseudo-random modes count raw clock.
// - Other modes: count step needs prescaled tick and event.
// - Fourteen shared lines plus constant 0, 1.
// - Each event selects any of 16 sources.
// - Reload flags overflow/underflow, start does not.
// - Software commands act like hardware triggers.
// - Start resumes with count unchanged.
// - Stop beats reload, reload beats start.
// - Per-event rise, fall, both or level.
// - Quadrature detects edges on counter clock.
// - Single-edge modes merge pending edges.
// - Both-edge mode keeps only odd parity.
// - Trigger lines synchronised before use.
// - Up count leaving period raises overflow.
// - Down count leaving zero raises underflow.
// - Compare match on arrival or departure.
// - Capture raises compare/capture event.
// - Output triggers last two system cycles.
// - Mode field codes 011, 101, 110.
module ctl_front
    import ctl_pkg::*;
#(
    parameter int CNT_W = 16
) (
    input  wire logic                     clk,
    input  wire logic                     rstn,
    input  wire logic                     psel,
    input  wire logic                     penable,
    input  wire logic                     pwrite,
    input  wire logic [7:0]               paddr,
    input  wire logic [31:0]              pwdata,
    output logic      [31:0]              prdata,
    output logic                          pready,
    output logic                          pslverr,
    input  wire logic [CTL_NUM_LINES-1:0] trigger_in,
    output logic                          overflow_event,
    output logic                          underflow_event,
    output logic                          compare_capture_event
);

    if (CNT_W < 2 || CNT_W > 32) begin : g_chk
        $error("CNT_W must lie in 2..32");
    end

    typedef struct packed {
        logic [CTL_NUM_LINES-1:0] sync1;
        logic [CTL_NUM_LINES-1:0] sync2;
        logic [CTL_NUM_EV-1:0]    prev;
        logic [CTL_NUM_EV-1:0]    pend;
        logic [CTL_NUM_EV-1:0]    cmd;
        logic                     enable;
        logic                     cc_leave;
        logic                     down;
        logic [2:0]               mode;
        logic [2:0]               prescale_select;
        logic [7:0]               divider_select;
        logic [7:0]               sys_select;
        logic [7:0]               div_cnt;
        logic [7:0]               sys_cnt;
        logic [6:0]               presc_cnt;
        logic [4*CTL_NUM_EV-1:0]  trigger_source_select;
        logic [2*CTL_NUM_EV-1:0]  trigger_edge_select;
        logic                     running;
        logic [CNT_W-1:0]         counter;
        logic [CNT_W-1:0]         period;
        logic [CNT_W-1:0]         cc;
        logic [CNT_W-1:0]         compare_capture_buffer;
        logic [2:0]               out_req;
        logic [5:0]               out_cnt;
        logic [2:0]               outs;
        logic [31:0]              prdata;
        logic                     pslverr;
    } ctl_state_t;

    ctl_state_t st_reg;
    ctl_state_t st_next;

    // Edge condition for one conditioner setting
    function automatic logic edge_hit(input logic [1:0] sel, input logic cur, input logic old);
        logic hit;
        hit = 1'b0;
        case (sel)
            CTL_EDGE_RISE: hit = cur & ~old;
            CTL_EDGE_FALL: hit = ~cur & old;
            CTL_EDGE_BOTH: hit = cur ^ old;
            default:       hit = 1'b0;
        endcase
        return hit;
    endfunction

    // Known register offset check
    function automatic logic addr_ok(input logic [7:0] a);
        return a == CTL_OFS_CTRL || a == CTL_OFS_DIV || a == CTL_OFS_SRC ||
               a == CTL_OFS_EDGE || a == CTL_OFS_CMD || a == CTL_OFS_COUNTER ||
               a == CTL_OFS_PERIOD || a == CTL_OFS_CC || a == CTL_OFS_CCBUF ||
               a == CTL_OFS_STATUS;
    endfunction

    logic [CTL_NUM_SRC-1:0] src_vec;
    logic [CTL_NUM_EV-1:0]  lvl;
    logic [CTL_NUM_EV-1:0]  hit;
    logic [CTL_NUM_EV-1:0]  evt;
    logic [CTL_NUM_EV-1:0]  consume;
    logic                   cnt_tick;
    logic                   sys_tick;
    logic                   presc_tick;
    logic                   bypass;
    logic                   raw_mode;
    logic                   count_en;
    logic                   samp;
    logic                   do_stop;
    logic                   do_reload;
    logic                   do_start;
    logic                   wr;
    logic                   rd;
    logic [6:0]             presc_mask;
    logic [CNT_W-1:0]       cnt_new;
    logic                   ovf;
    logic                   unf;
    logic                   ccev;

    // Tick generation and event resolution
    always_comb begin
        st_next  = st_reg;
        wr       = psel & penable & pwrite;
        rd       = psel & ~penable & ~pwrite;
        src_vec  = {st_reg.sync2, 1'b1, 1'b0};
        cnt_tick = st_reg.div_cnt == st_reg.divider_select;
        sys_tick = st_reg.sys_cnt == st_reg.sys_select;
        // no prescaler in quadrature or dead time
        bypass   = st_reg.mode == CTL_MODE_QUAD || st_reg.mode == CTL_MODE_DT;
        raw_mode = st_reg.mode == CTL_MODE_QUAD || st_reg.mode == CTL_MODE_PR;
        presc_mask = 7'((8'h01 << st_reg.prescale_select) - 8'h01);
        presc_tick = cnt_tick & (bypass | ((st_reg.presc_cnt & presc_mask) == presc_mask));
        samp = (st_reg.mode == CTL_MODE_QUAD) ? cnt_tick : 1'b1;
        for (int i = 0; i < CTL_NUM_EV; i++) begin
            lvl[i] = src_vec[st_reg.trigger_source_select[4*i +: 4]];
            hit[i] = samp & edge_hit(st_reg.trigger_edge_select[2*i +: 2], lvl[i],
                                     st_reg.prev[i]);
            if (st_reg.trigger_edge_select[2*i +: 2] == CTL_EDGE_LEVEL) begin
                evt[i] = lvl[i] | st_reg.cmd[i];
            end else begin
                // edge input acts on detected edge
                evt[i] = hit[i] | st_reg.pend[i] | st_reg.cmd[i];
            end
            consume[i] = (i == CTL_EV_COUNT) ? presc_tick : cnt_tick;
        end
        do_stop   = cnt_tick & evt[CTL_EV_STOP];
        do_reload = cnt_tick & evt[CTL_EV_RELOAD] & ~do_stop;
        do_start  = cnt_tick & evt[CTL_EV_START] & ~do_stop & ~do_reload;
        // raw clock and no count trigger
        count_en = raw_mode ? cnt_tick : (presc_tick & evt[CTL_EV_COUNT]);
        ovf      = 1'b0;
        unf      = 1'b0;
        ccev     = 1'b0;
        cnt_new  = st_reg.counter;
        // Dividers and prescale counter
        st_next.div_cnt = cnt_tick ? 8'h00 : 8'(st_reg.div_cnt + 8'h01);
        st_next.sys_cnt = sys_tick ? 8'h00 : 8'(st_reg.sys_cnt + 8'h01);
        if (cnt_tick) begin
            st_next.presc_cnt = 7'(st_reg.presc_cnt + 7'h01);
        end
        st_next.sync1 = trigger_in;
        st_next.sync2 = st_reg.sync1;
        for (int i = 0; i < CTL_NUM_EV; i++) begin
            if (samp) begin
                st_next.prev[i] = lvl[i];
            end
            if (consume[i]) begin
                st_next.pend[i] = 1'b0;
                st_next.cmd[i]  = 1'b0;
            end else if (st_reg.trigger_edge_select[2*i +: 2] == CTL_EDGE_BOTH) begin
                st_next.pend[i] = st_reg.pend[i] ^ hit[i];
            end else begin
                st_next.pend[i] = st_reg.pend[i] | hit[i];
            end
        end
        if (st_reg.enable) begin
            if (do_stop) begin
                st_next.running = 1'b0;
            end else if (do_reload) begin
                st_next.running = 1'b1;
                cnt_new = st_reg.down ? st_reg.period : '0;
                ovf     = ~st_reg.down;
                unf     = st_reg.down;
            end else if (do_start) begin
                st_next.running = 1'b1;
            end
            if (st_reg.running & count_en & ~do_stop & ~do_reload) begin
                if (!st_reg.down) begin
                    ovf     = st_reg.counter == st_reg.period;
                    cnt_new = ovf ? '0 : CNT_W'(st_reg.counter + 1'b1);
                end else begin
                    unf     = st_reg.counter == '0;
                    cnt_new = unf ? st_reg.period : CNT_W'(st_reg.counter - 1'b1);
                end
                if (cnt_new != st_reg.counter) begin
                    ccev = st_reg.cc_leave ? (st_reg.counter == st_reg.cc)
                                           : (cnt_new == st_reg.cc);
                end
            end
            if (cnt_tick & evt[CTL_EV_CAPT]) begin
                st_next.compare_capture_buffer = st_reg.cc;
                st_next.cc = st_reg.counter;
                ccev = 1'b1;
            end
        end else begin
            st_next.running = 1'b0;
        end
        st_next.counter = cnt_new;
        // requests wait for a system tick, then hold two ticks
        for (int k = 0; k < 3; k++) begin
            if (sys_tick && st_reg.out_req[k]) begin
                st_next.out_cnt[2*k +: 2] = CTL_PULSE_SYS;
            end else if (sys_tick && st_reg.out_cnt[2*k +: 2] != 2'h0) begin
                st_next.out_cnt[2*k +: 2] = 2'(st_reg.out_cnt[2*k +: 2] - 2'h1);
            end
            st_next.outs[k]    = st_next.out_cnt[2*k +: 2] != 2'h0;
            st_next.out_req[k] = st_reg.out_req[k] & ~sys_tick;
        end
        st_next.out_req = st_next.out_req | {ccev, unf, ovf};
        // Register read in setup phase
        st_next.pslverr = psel & ~penable & ~addr_ok(paddr);
        if (rd) begin
            case (paddr)
                CTL_OFS_CTRL:    st_next.prdata = {5'h00, st_reg.mode, 7'h00, st_reg.down,
                                                   5'h00, st_reg.prescale_select, 3'h0,
                                                   st_reg.cc_leave, 3'h0, st_reg.enable};
                CTL_OFS_DIV:     st_next.prdata = {16'h0000, st_reg.sys_select,
                                                   st_reg.divider_select};
                CTL_OFS_SRC:     st_next.prdata = 32'(st_reg.trigger_source_select);
                CTL_OFS_EDGE:    st_next.prdata = 32'(st_reg.trigger_edge_select);
                CTL_OFS_COUNTER: st_next.prdata = 32'(st_reg.counter);
                CTL_OFS_PERIOD:  st_next.prdata = 32'(st_reg.period);
                CTL_OFS_CC:      st_next.prdata = 32'(st_reg.cc);
                CTL_OFS_CCBUF:   st_next.prdata = 32'(st_reg.compare_capture_buffer);
                CTL_OFS_STATUS:  st_next.prdata = {28'h0000000, st_reg.outs, st_reg.running};
                default:         st_next.prdata = 32'h0000_0000;
            endcase
        end
        // Register write in access phase, software wins over counting
        if (wr) begin
            case (paddr)
                CTL_OFS_CTRL: begin
                    st_next.enable          = pwdata[CTL_EN_BIT];
                    st_next.cc_leave        = pwdata[CTL_LEAVE_BIT];
                    st_next.prescale_select = pwdata[CTL_PRESC_LSB +: 3];
                    st_next.down            = pwdata[CTL_DOWN_BIT];
                    st_next.mode            = pwdata[CTL_MODE_LSB +: 3];
                end
                CTL_OFS_DIV: begin
                    st_next.divider_select = pwdata[CTL_CDIV_LSB +: 8];
                    st_next.sys_select     = pwdata[CTL_SDIV_LSB +: 8];
                    st_next.div_cnt        = 8'h00;
                    st_next.sys_cnt        = 8'h00;
                end
                CTL_OFS_SRC:     st_next.trigger_source_select = pwdata[4*CTL_NUM_EV-1:0];
                CTL_OFS_EDGE:    st_next.trigger_edge_select   = pwdata[2*CTL_NUM_EV-1:0];
                // command bits set win over consume
                CTL_OFS_CMD:     st_next.cmd = st_next.cmd | {pwdata[CTL_EV_CAPT],
                                                              1'b0, pwdata[2:0]};
                CTL_OFS_COUNTER: st_next.counter = pwdata[CNT_W-1:0];
                CTL_OFS_PERIOD:  st_next.period  = pwdata[CNT_W-1:0];
                CTL_OFS_CC:      st_next.cc      = pwdata[CNT_W-1:0];
                default:         st_next.enable  = st_next.enable;
            endcase
        end
    end

    // State register
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            st_reg                 <= '0;
            st_reg.enable          <= CTL_CTRL_RST[CTL_EN_BIT];
            st_reg.divider_select  <= CTL_DIV_RST;
            st_reg.sys_select      <= CTL_DIV_RST;
            st_reg.period          <= '1;
        end else begin
            st_reg <= st_next;
        end
    end

    // Bus and trigger outputs
    assign prdata                = st_reg.prdata;
    assign pready                = 1'b1;
    assign pslverr               = st_reg.pslverr;
    assign overflow_event        = st_reg.outs[0];
    assign underflow_event       = st_reg.outs[1];
    assign compare_capture_event = st_reg.outs[2];

    // Length of the overflow pulse in clk cycles
    logic [10:0] ovf_len_reg;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ovf_len_reg <= 11'h000;
        end else begin
            ovf_len_reg <= overflow_event ? 11'(ovf_len_reg + 11'h001) : 11'h000;
        end
    end

    a_prescale_tick: assert property (@(posedge clk) disable iff (!rstn)
        presc_tick && !bypass |-> cnt_tick && (st_reg.presc_cnt & presc_mask) == presc_mask)
        else $error("prescaled tick without full prescale count");
    a_bypass_tick: assert property (@(posedge clk) disable iff (!rstn)
        cnt_tick && bypass |-> presc_tick)
        else $error("bypass mode lost a counter tick");
    a_count_gate: assert property (@(posedge clk) disable iff (!rstn)
        st_reg.enable && !raw_mode && !evt[CTL_EV_COUNT] && !do_reload && !wr
        |=> st_reg.counter == $past(st_reg.counter))
        else $error("count step without event");
    a_stop_wins: assert property (@(posedge clk) disable iff (!rstn)
        st_reg.enable && do_stop && !wr |=> !st_reg.running)
        else $error("counter still running after stop");
    a_reload_flag: assert property (@(posedge clk) disable iff (!rstn)
        st_reg.enable && do_reload && !st_reg.down |=> st_reg.out_req[0]
        || $past(sys_tick) && st_reg.out_cnt[1:0] == CTL_PULSE_SYS)
        else $error("reload did not flag overflow");
    a_start_hold: assert property (@(posedge clk) disable iff (!rstn)
        st_reg.enable && do_start && !st_reg.running && !wr
        |=> st_reg.counter == $past(st_reg.counter))
        else $error("start changed the count");
    a_sync_delay: assert property (@(posedge clk) disable iff (!rstn)
        st_reg.sync2 == $past(trigger_in, 2))
        else $error("trigger synchroniser depth wrong");
    a_both_parity: assert property (@(posedge clk) disable iff (!rstn)
        st_reg.trigger_edge_select[1:0] == CTL_EDGE_BOTH && !consume[0] && !wr
        && st_reg.pend[0] && hit[0] |=> !st_reg.pend[0])
        else $error("both-edge parity broken");
    // overflow pulse is two system periods
    a_pulse_width: assert property (@(posedge clk) disable iff (!rstn)
        $fell(overflow_event) && $stable(st_reg.sys_select)
        |-> $past(ovf_len_reg) == 11'(2 * (st_reg.sys_select + 1) - 1))
        else $error("overflow pulse width wrong");
    a_ovf_wrap: assert property (@(posedge clk) disable iff (!rstn)
        st_reg.enable && st_reg.running && count_en && !st_reg.down && !do_stop
        && !do_reload && !wr && st_reg.counter == st_reg.period |=> st_reg.counter == '0)
        else $error("overflow did not wrap");

    c_reload_run: cover property (@(posedge clk) disable iff (!rstn)
        do_reload ##1 st_reg.running);
    c_overflow: cover property (@(posedge clk) disable iff (!rstn) $rose(overflow_event));
    c_capture: cover property (@(posedge clk) disable iff (!rstn)
        cnt_tick && evt[CTL_EV_CAPT] && st_reg.enable);
    c_stop_reload: cover property (@(posedge clk) disable iff (!rstn)
        cnt_tick && evt[CTL_EV_STOP] && evt[CTL_EV_RELOAD]);

endmodule

`default_nettype wire

// [verif/ctl_trig_src.sv]
// Trigger source model standing in for other on-chip peripherals
`timescale 1ns/1ps
`default_nettype none
module ctl_trig_src (
    input  wire logic        clk,
    output logic      [13:0] lines
);
    initial lines = 14'h0000;
    // Change one line just after a clock edge
    task automatic set_line(input int idx, input logic v);
        @(posedge clk);
        lines[idx] <= v;
    endtask
    // Pulses of four cycles high, four low
    task automatic pulses(input int idx, input int n);
        for (int i = 0; i < n; i++) begin
            set_line(idx, 1'b1);
            repeat (3) @(posedge clk);
            set_line(idx, 1'b0);
            repeat (3) @(posedge clk);
        end
    endtask
endmodule
`default_nettype wire

// [verif/tb_top.sv]
// Self-checking testbench for the counter clock and trigger front end
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import ctl_pkg::*;
;
    logic        clk = 1'b0;
    logic        rstn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] rd;
    logic        err;
    int          w;
    int          fail_count = 0;
    int          n_checks = 0;
    int          cyc = 0;
    wire  [31:0] prdata;
    wire         pready;
    wire         pslverr;
    wire  [13:0] trigger_in;
    wire  [2:0]  ev;

    ctl_front #(.CNT_W(16)) ctl_front_i (.clk(clk), .rstn(rstn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .trigger_in(trigger_in),
        .overflow_event(ev[0]), .underflow_event(ev[1]), .compare_capture_event(ev[2]));
    ctl_trig_src ctl_trig_src_i (.clk(clk), .lines(trigger_in));

    // 8 ns clock
    initial forever #4 clk = ~clk;

    // Cut a hang short
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            fail_count++;
            print_verdict();
        end
    end

    task automatic print_verdict();
        if (fail_count == 0 && n_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // One APB transfer, held until pready is sampled high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Cycles that one output event stays high
    task automatic pulse_len(input int k, output int n);
        n = 0;
        repeat (30) begin
            @(posedge clk);
            if (ev[k] === 1'b1) n++;
        end
    endtask

    // Count for about 80 cycles under one setup
    task automatic run_case(input logic [31:0] ctl, input logic [31:0] src,
                            input logic [31:0] edg, input int np, input int lo, input int hi);
        apb(1'b1, CTL_OFS_CMD, 32'h4);
        apb(1'b1, CTL_OFS_COUNTER, 32'h0);
        apb(1'b1, CTL_OFS_SRC, src);
        apb(1'b1, CTL_OFS_EDGE, edg);
        apb(1'b1, CTL_OFS_CTRL, ctl);
        apb(1'b1, CTL_OFS_CMD, 32'h2);
        ctl_trig_src_i.pulses(1, np);
        repeat (80 - np * 8) @(posedge clk);
        apb(1'b1, CTL_OFS_CMD, 32'h4);
        apb(1'b0, CTL_OFS_COUNTER, 32'h0);
        chk("counter", {31'h0, (rd >= lo && rd <= hi)}, 32'h1);
    endtask

    // Main sequence
    initial begin
        repeat (6) @(posedge clk);
        rstn <= 1'b1;
        apb(1'b0, CTL_OFS_PERIOD, 32'h0);
        chk("period", rd, 32'h0000FFFF);
        apb(1'b0, CTL_OFS_CTRL, 32'h0);
        chk("ctrl", rd, CTL_CTRL_RST);
        apb(1'b0, 8'h28, 32'h0);
        chk("unmapped", {31'h0, err}, 32'h1);
        chk("ready", {31'h0, pready}, 32'h1);
        // Always-counting setup, then software commands
        apb(1'b1, CTL_OFS_SRC, 32'h0000_1000);
        apb(1'b1, CTL_OFS_EDGE, 32'h0000_00C0);
        apb(1'b1, CTL_OFS_CTRL, 32'h1);
        apb(1'b1, CTL_OFS_CMD, 32'h1);
        pulse_len(0, w);
        chk("reload overflow", 32'(w), 32'h2);
        apb(1'b1, CTL_OFS_CMD, 32'h4);
        apb(1'b1, CTL_OFS_CMD, 32'h2);
        pulse_len(0, w);
        chk("start overflow", 32'(w), 32'h0);
        apb(1'b1, CTL_OFS_CMD, 32'h7);
        apb(1'b0, CTL_OFS_STATUS, 32'h0);
        chk("running", {31'h0, rd[0]}, 32'h0);
        apb(1'b1, CTL_OFS_CMD, 32'h3);
        pulse_len(0, w);
        chk("reload over start", 32'(w), 32'h2);
        apb(1'b1, CTL_OFS_CMD, 32'h10);
        pulse_len(2, w);
        chk("capture event", 32'(w), 32'h2);
        apb(1'b1, CTL_OFS_CTRL, 32'h0001_0001);
        apb(1'b1, CTL_OFS_CMD, 32'h1);
        pulse_len(1, w);
        chk("reload underflow", 32'(w), 32'h2);
        // Clock path and trigger conditioning cases
        run_case(32'h0000_0301, 32'h1000, 32'hC0, 0, 9, 11);
        run_case(32'h0500_0301, 32'h1000, 32'hC0, 0, 78, 86);
        run_case(32'h0600_0001, 32'h0000, 32'hC0, 0, 78, 86);
        run_case(32'h0000_0001, 32'h2000, 32'hC0, 0, 0, 0);
        run_case(32'h0000_0001, 32'h3000, 32'h00, 3, 3, 3);
        run_case(32'h0000_0001, 32'h3000, 32'h40, 3, 3, 3);
        run_case(32'h0000_0001, 32'h3000, 32'h80, 3, 6, 6);
        run_case(32'h0000_0001, 32'h3000, 32'hC0, 3, 11, 13);
        run_case(32'h0300_0301, 32'h0000, 32'hC0, 0, 78, 86);
        // Overflow and compare match while counting up to a short period
        apb(1'b1, CTL_OFS_PERIOD, 32'h40);
        apb(1'b1, CTL_OFS_CC, 32'h3E);
        apb(1'b1, CTL_OFS_SRC, 32'h1000);
        apb(1'b1, CTL_OFS_EDGE, 32'hC0);
        apb(1'b1, CTL_OFS_CTRL, 32'h1);
        apb(1'b1, CTL_OFS_COUNTER, 32'h3C);
        apb(1'b1, CTL_OFS_CMD, 32'h2);
        pulse_len(0, w);
        chk("count overflow", 32'(w), 32'h2);
        apb(1'b1, CTL_OFS_CMD, 32'h4);
        apb(1'b1, CTL_OFS_COUNTER, 32'h3C);
        apb(1'b1, CTL_OFS_CMD, 32'h2);
        pulse_len(2, w);
        chk("match on arrival", 32'(w), 32'h2);
        // Departure mode fires on the first step away from the compare value
        apb(1'b1, CTL_OFS_CMD, 32'h4);
        apb(1'b1, CTL_OFS_CTRL, 32'h11);
        apb(1'b1, CTL_OFS_COUNTER, 32'h3E);
        apb(1'b1, CTL_OFS_CMD, 32'h2);
        pulse_len(2, w);
        chk("match on departure", 32'(w), 32'h2);
        // System tick every second clock stretches the pulse to four clocks
        apb(1'b1, CTL_OFS_DIV, 32'h0000_0100);
        apb(1'b1, CTL_OFS_CMD, 32'h1);
        pulse_len(0, w);
        chk("slow system overflow", 32'(w), 32'h4);
        print_verdict();
    end
endmodule
`default_nettype wire
